// *** common/tcc_pkg.sv ***
// constants and types shared by the timer/counter core
// assumes one system clock; pins reach the core through synchronisers
package tcc_pkg;

    localparam logic [7:0] TCC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] TCC_OFS_STATUS = 8'h04;
    localparam logic [7:0] TCC_OFS_COUNT  = 8'h08;
    localparam logic [7:0] TCC_OFS_PER    = 8'h0c;
    localparam logic [7:0] TCC_OFS_CC0    = 8'h10;
    localparam logic [7:0] TCC_OFS_CC1    = 8'h14;

    // control register field positions
    localparam int TCC_CTRL_EN     = 0;
    localparam int TCC_CTRL_MODE   = 1;
    localparam int TCC_CTRL_WAVE   = 3;
    localparam int TCC_CTRL_DIR    = 5;
    localparam int TCC_CTRL_EVACT  = 6;
    localparam int TCC_CTRL_PRESC  = 8;
    localparam int TCC_CTRL_DBGRUN = 11;
    localparam int TCC_CTRL_CPTEN  = 12;
    localparam int TCC_CTRL_INVEN  = 14;
    localparam int TCC_CTRL_EVEDGE = 16;
    localparam int TCC_CTRL_BITS   = 17;

    localparam logic [31:0] TCC_CNT_RST = 32'h0000_0000;
    localparam logic [31:0] TCC_CC_RST  = 32'h0000_0000;
    localparam logic [7:0]  TCC_PER_RST = 8'hff;
    localparam logic [31:0] TCC_MAX8    = 32'h0000_00ff;
    localparam logic [31:0] TCC_MAX16   = 32'h0000_ffff;
    localparam logic [31:0] TCC_MAX32   = 32'hffff_ffff;

    typedef enum logic [1:0] {TCC_M16, TCC_M8, TCC_M32, TCC_MRSV} tcc_mode_t;
    typedef enum logic [1:0] {TCC_NFRQ, TCC_MFRQ, TCC_NPWM, TCC_MPWM} tcc_wave_t;
    typedef enum logic [1:0] {
        TCC_EV_OFF, TCC_EV_RETRIG, TCC_EV_COUNT, TCC_EV_CAPT
    } tcc_evact_t;

endpackage

// *** rtl/tcc_core.sv ***
// timer/counter core with two compare/capture channels and ahb-lite slave
// assumes a single-slave ahb-lite bus; gclk_i and event_i are async pins
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcc_core
    import tcc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        gclk_i,
    input  wire logic        event_i,
    input  wire logic        dbg_halt_i,
    input  wire logic        dbg_access_i,
    input  wire logic        access_guard_i,
    output logic [1:0]       waveform_out_lines_o,
    output logic             ovf_evt_o,
    output logic [1:0]       match_evt_o,
    output logic             dma_req_o
);
    typedef struct packed {
        logic             en;
        tcc_mode_t        mode;
        tcc_wave_t        wave;
        logic             dir;
        tcc_evact_t       evact;
        logic [2:0]       presc;
        logic             dbgrun;
        logic [1:0]       cpten;
        logic [1:0]       inven;
        logic             evedge;
        logic             run;
        logic [31:0]      cnt;
        logic [7:0]       period_value;
        logic [1:0][31:0] cc;
        logic [1:0]       wo;
        logic [2:0]       gs;
        logic [2:0]       es;
        logic             ovf;
        logic [1:0]       mc;
        logic             wr_pend;
        logic             wr_dbg;
        logic [7:0]       wr_addr;
        logic [31:0]      rdata;
    } tcc_core_st_t;

    tcc_core_st_t q;
    tcc_core_st_t d;

    // all-ones value of the selected resolution
    function automatic logic [31:0] max_of(tcc_mode_t m);
        if (m == TCC_M8) begin
            return TCC_MAX8;
        end
        if (m == TCC_M32) begin
            return TCC_MAX32;
        end
        return TCC_MAX16;
    endfunction

    // top from channel 0 in match modes, else period in 8-bit mode or all-ones
    function automatic logic [31:0] top_of(tcc_mode_t m, tcc_wave_t w,
                                           logic [7:0] p, logic [31:0] c0);
        if (w == TCC_MFRQ || w == TCC_MPWM) begin
            return c0 & max_of(m);
        end
        if (m == TCC_M8) begin
            return {24'h000000, p};
        end
        return max_of(m);
    endfunction

    logic [31:0] mx;
    logic [31:0] top_w;
    logic        at_zero;
    logic        at_top;
    logic        gclk_rise;
    logic        ev_rise;
    logic        ev_edge;
    logic        presc_tick;
    logic        halted;
    logic        cnt_tick;
    logic        acc;
    logic        cnt_wr;
    logic [1:0]  match_w;
    logic [31:0] ctrl_w;

    // width of count and compare follows the mode
    assign mx      = max_of(q.mode);
    assign top_w   = top_of(q.mode, q.wave, q.period_value, q.cc[0]);
    assign at_zero = (q.cnt & mx) == '0;
    assign at_top  = (q.cnt & mx) == top_w;

    // synchronised counting clock, edge from second stage on
    assign gclk_rise = q.gs[1] && !q.gs[2];
    assign ev_rise   = q.es[1] && !q.es[2];
    assign ev_edge   = q.evedge ? (!q.es[1] && q.es[2]) : ev_rise;

    // one generic clock feeds both halves of the 32-bit pair
    tcc_presc #(
        .CW (10)
    ) u_presc (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .tick_i    (gclk_rise),
        .clear_i   (!q.run),
        .sel_i     (q.presc),
        .tick_o    (presc_tick)
    );

    assign halted = dbg_halt_i && !q.dbgrun;
    // no sleep gating; counting runs while the clock runs
    assign cnt_tick = q.en && q.run && !halted &&
                      ((q.evact == TCC_EV_COUNT) ? ev_rise : presc_tick);

    // two compare channels, masked to the resolution
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cmp
            assign match_w[gi] = (q.cnt & mx) == (q.cc[gi] & mx);
        end
    endgenerate

    assign acc    = hsel_i && htrans_i[1] && hready_i;
    assign cnt_wr = q.wr_pend && q.wr_addr == TCC_OFS_COUNT;
    assign ctrl_w = {15'h0000, q.evedge, q.inven, q.cpten, q.dbgrun,
                     q.presc, q.evact, q.dir, q.wave, q.mode, q.en};

    always_comb begin
        d     = q;
        d.ovf = 1'b0;
        d.mc  = 2'b00;
        d.gs  = {q.gs[1:0], gclk_i};
        d.es  = {q.es[1:0], event_i};
        if (cnt_tick) begin
            if (!q.dir) begin
                d.cnt = at_top ? '0 : (q.cnt + 32'h1) & mx;
            end else begin
                d.cnt = at_zero ? top_w : (q.cnt - 32'h1) & mx;
            end
            // update at top going up, at zero going down
            // update drives event and dma request
            d.ovf = q.dir ? at_zero : at_top;
        end
        for (int i = 0; i < 2; i++) begin
            if (cnt_tick && match_w[i]) begin
                d.mc[i] = 1'b1;
            end
        end
        // capture on the selected event edge
        if (q.en && q.evact == TCC_EV_CAPT && ev_edge) begin
            for (int i = 0; i < 2; i++) begin
                if (q.cpten[i]) begin
                    d.cc[i] = q.cnt & mx;
                    d.mc[i] = 1'b1;
                end
            end
        end
        if (q.en && q.evact == TCC_EV_RETRIG && ev_rise) begin
            d.run = 1'b1;
            d.cnt = q.dir ? top_w : '0;
        end
        // ahb data phase write; beats counting and capture
        if (q.wr_pend) begin
            unique case (q.wr_addr)
                TCC_OFS_CTRL: begin
                    if (!access_guard_i || q.wr_dbg) begin
                        d.en     = hwdata_i[TCC_CTRL_EN];
                        d.mode   = tcc_mode_t'(hwdata_i[TCC_CTRL_MODE +: 2]);
                        d.wave   = tcc_wave_t'(hwdata_i[TCC_CTRL_WAVE +: 2]);
                        d.dir    = hwdata_i[TCC_CTRL_DIR];
                        d.evact  =
                            tcc_evact_t'(hwdata_i[TCC_CTRL_EVACT +: 2]);
                        d.presc  = hwdata_i[TCC_CTRL_PRESC +: 3];
                        d.dbgrun = hwdata_i[TCC_CTRL_DBGRUN];
                        d.cpten  = hwdata_i[TCC_CTRL_CPTEN +: 2];
                        d.inven  = hwdata_i[TCC_CTRL_INVEN +: 2];
                        d.evedge = hwdata_i[TCC_CTRL_EVEDGE];
                        if (!hwdata_i[TCC_CTRL_EN]) begin
                            d.run = 1'b0;
                        end else if (!q.en) begin
                            // retrigger mode waits for its event
                            d.run = hwdata_i[TCC_CTRL_EVACT +: 2] !=
                                    TCC_EV_RETRIG;
                        end
                    end
                end
                TCC_OFS_COUNT: d.cnt = hwdata_i & max_of(d.mode);
                TCC_OFS_PER:   d.period_value = hwdata_i[7:0];
                TCC_OFS_CC0:   d.cc[0] = hwdata_i & max_of(d.mode);
                TCC_OFS_CC1:   d.cc[1] = hwdata_i & max_of(d.mode);
                default: ;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            if (!d.en) begin
                d.wo[i] = d.inven[i];
            end else if (d.wave == TCC_NPWM || d.wave == TCC_MPWM) begin
                d.wo[i] = ((d.cnt & max_of(d.mode)) <
                           (d.cc[i] & max_of(d.mode))) ^ d.inven[i];
            end else if (d.mc[i] && cnt_tick) begin
                d.wo[i] = !q.wo[i];
            end
        end
        d.wr_pend = acc && hwrite_i;
        d.wr_dbg  = dbg_access_i;
        d.wr_addr = haddr_i[7:0];
        if (acc && !hwrite_i) begin
            unique case (haddr_i[7:0])
                TCC_OFS_CTRL:   d.rdata = ctrl_w;
                TCC_OFS_STATUS: d.rdata = {27'h0, q.mode == TCC_M32,
                                           (q.cnt & mx) == mx, at_top,
                                           at_zero, q.run};
                TCC_OFS_COUNT:  d.rdata = q.cnt & mx;
                TCC_OFS_PER:    d.rdata = {24'h000000, q.period_value};
                TCC_OFS_CC0:    d.rdata = q.cc[0] & mx;
                TCC_OFS_CC1:    d.rdata = q.cc[1] & mx;
                default:        d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q       <= '0;
            q.mode  <= TCC_M16;
            q.wave  <= TCC_NFRQ;
            q.evact <= TCC_EV_OFF;
            q.cnt   <= TCC_CNT_RST;
            q.period_value   <= TCC_PER_RST;
            q.cc    <= {TCC_CC_RST, TCC_CC_RST};
        end else begin
            q <= d;
        end
    end

    // 32-bit mode uses both halves of the one counter
    assign hrdata_o             = q.rdata;
    assign hreadyout_o          = 1'b1;
    assign hresp_o              = 1'b0;
    assign waveform_out_lines_o = q.wo;
    assign ovf_evt_o            = q.ovf;
    assign match_evt_o          = q.mc;
    assign dma_req_o            = q.ovf;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    logic quiet;
    assign quiet = !q.wr_pend && q.evact != TCC_EV_RETRIG;

    sequence s_tick_up_top;
        cnt_tick && !q.dir && at_top && quiet;
    endsequence
    sequence s_tick_dn_zero;
        cnt_tick && q.dir && at_zero && quiet;
    endsequence
    sequence s_prot_wr;
        acc && hwrite_i && haddr_i[7:0] == TCC_OFS_CTRL &&
        access_guard_i && !dbg_access_i;
    endsequence

    chk_wrap_up: assert property (
        s_tick_up_top |=> q.cnt == '0)
        else $error("up count did not wrap to zero");
    chk_wrap_down: assert property (
        s_tick_dn_zero |=> q.cnt == $past(top_w))
        else $error("down count did not reload top");
    chk_update_pulse: assert property (
        (s_tick_up_top or s_tick_dn_zero) |=> ovf_evt_o && dma_req_o
        ##1 !ovf_evt_o)
        else $error("update pulse missing or too long");
    chk_halt_freeze: assert property (
        halted && quiet && q.evact != TCC_EV_CAPT |=> $stable(q.cnt))
        else $error("counter moved during debug halt");
    chk_match_pulse: assert property (
        cnt_tick && match_w[0] |=> match_evt_o[0])
        else $error("channel 0 match not signalled");
    chk_capture_store: assert property (
        q.en && q.evact == TCC_EV_CAPT && ev_edge && q.cpten[1] &&
        !q.wr_pend |=> q.cc[1] == ($past(q.cnt) & $past(mx)))
        else $error("capture did not store count");
    chk_ctrl_guard: assert property (
        s_prot_wr |-> ##2 ctrl_w == $past(ctrl_w, 2))
        else $error("protected control write took effect");
    chk_pwm_level: assert property (
        q.en && q.wave == TCC_NPWM |->
        waveform_out_lines_o[1] ==
        (((q.cnt & mx) < (q.cc[1] & mx)) ^ q.inven[1]))
        else $error("pwm line disagrees with compare");
    chk_count_event: assert property (
        q.evact == TCC_EV_COUNT && !cnt_tick && quiet |=> $stable(q.cnt))
        else $error("count changed without an event");
endmodule
`default_nettype wire

// *** rtl/tcc_presc.sv ***
// generic-clock prescaler: passes one tick out of 2^n
// assumes tick_i is a one-cycle pulse already in the system clock domain
`timescale 1ns/1ps
`default_nettype none
module tcc_presc #(
    parameter int CW = 10
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       tick_i,
    input  wire logic       clear_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [CW-1:0] cnt;
    } tcc_presc_st_t;

    tcc_presc_st_t q;
    tcc_presc_st_t d;
    logic [CW-1:0] lim;

    // divisors 1,2,4,8,16,64,256,1024
    always_comb begin
        unique case (sel_i)
            3'h0: lim = CW'(0);
            3'h1: lim = CW'(1);
            3'h2: lim = CW'(3);
            3'h3: lim = CW'(7);
            3'h4: lim = CW'(15);
            3'h5: lim = CW'(63);
            3'h6: lim = CW'(255);
            3'h7: lim = CW'(1023);
        endcase
    end

    assign tick_o = tick_i && (q.cnt >= lim);

    always_comb begin
        d = q;
        if (clear_i) begin
            d.cnt = '0;
        end else if (tick_i) begin
            d.cnt = (q.cnt >= lim) ? '0 : q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// *** tb/tcc_tick_src.sv ***
// far-side model: drives the generic clock pin and the input event line
// assumes the core samples both pins through its own synchronisers
`timescale 1ns/1ps
`default_nettype none
module tcc_tick_src (
    input  wire logic clk_sys_i,
    output logic      gclk_o,
    output logic      event_o
);
    initial begin
        gclk_o = 1'b0;
        event_o = 1'b0;
    end
    // lines rest low between bursts; half of 2 or more keeps edges apart
    task automatic burst(input int n, input int half, input bit ev);
        repeat (n) begin
            if (ev)
                event_o <= 1'b1;
            else
                gclk_o <= 1'b1;
            repeat (half) @(posedge clk_sys_i);
            event_o <= 1'b0;
            gclk_o <= 1'b0;
            repeat (half) @(posedge clk_sys_i);
        end
        repeat (6) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// *** tb/timer_counter_core_test.sv ***
// self-checking bench for the timer/counter core with a count model
// assumes a 40 MHz system clock and a single-slave ahb-lite bus
`timescale 1ns/1ps
`default_nettype none
module timer_counter_core_test;
    import tcc_pkg::*;
    logic        clk_sys_i, rstn_i, hsel, hwrite, halt, dacc, guard;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0]  htrans, wo, mt;
    logic        hrdy, hresp, gclk, evt, ovf, dma;
    int          n_mismatch, comparisons, cyc, n_ovf, n_dma, n_m0, n_m1, p;

    tcc_core u_tcc_core (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .gclk_i(gclk), .event_i(evt), .dbg_halt_i(halt),
        .dbg_access_i(dacc), .access_guard_i(guard),
        .waveform_out_lines_o(wo), .ovf_evt_o(ovf), .match_evt_o(mt),
        .dma_req_o(dma));
    tcc_tick_src u_src (.clk_sys_i(clk_sys_i), .gclk_o(gclk), .event_o(evt));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        n_ovf <= n_ovf + int'(ovf === 1'b1);
        n_dma <= n_dma + int'(dma === 1'b1);
        n_m0 <= n_m0 + int'(mt[0] === 1'b1);
        n_m1 <= n_m1 + int'(mt[1] === 1'b1);
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input bit dbg = 1'b0);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        dacc <= dbg;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        dacc <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] msk, input string m);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
        chk(hrdata & msk, e, m);
        chk({31'h0, hresp}, 32'h0, "response");
        chk({31'h0, hrdy}, 32'h1, "ready");
    endtask
    // ns pins toggled, nm ticks expected to reach the counter
    task automatic run_cnt(input logic [31:0] ctrl, input longint st,
                           input int ns, input int nm, input longint top,
                           input longint cc1, input string m);
        longint c;
        int     o0, d0, m0, ov, mc;
        c = st;
        ov = 0;
        mc = 0;
        // mode goes in first so that the value writes are masked to it
        wr(TCC_OFS_CTRL, ctrl & ~32'h1);
        wr(TCC_OFS_CC1, cc1[31:0]);
        wr(TCC_OFS_COUNT, st[31:0]);
        wr(TCC_OFS_CTRL, ctrl);
        o0 = n_ovf;
        d0 = n_dma;
        m0 = n_m1;
        u_src.burst(ns, 2 + $urandom % 3, ctrl[7:6] == 2'd2);
        for (int i = 0; i < nm; i++) begin
            if (c == cc1)
                mc++;
            if (ctrl[5] ? c == 0 : c == top) begin
                ov++;
                c = ctrl[5] ? top : 0;
            end else
                c = ctrl[5] ? c - 1 : c + 1;
        end
        rc(TCC_OFS_COUNT, c[31:0], '1, m);
        chk(n_ovf - o0, ov, "update pulses");
        chk(n_dma - d0, ov, "dma requests");
        chk(n_m1 - m0, mc, "ch1 matches");
        chk({31'h0, wo[1]}, mc % 2, "ch1 toggle");
        wr(TCC_OFS_CTRL, 32'h0);
        $display("test %s done", m);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {rstn_i, hsel, hwrite, halt, dacc, guard, htrans} = '0;
        {haddr, hwdata, cyc, n_ovf, n_dma, n_m0, n_m1} = '0;
        n_mismatch = 0;
        comparisons = 0;
        v = $urandom(32'h8edc);
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        rc(TCC_OFS_CTRL, 32'h0, '1, "ctrl reset");
        rc(TCC_OFS_COUNT, TCC_CNT_RST, '1, "count reset");
        rc(TCC_OFS_PER, {24'h0, TCC_PER_RST}, '1, "per reset");
        rc(TCC_OFS_CC0, TCC_CC_RST, '1, "cc0 reset");
        rc(TCC_OFS_CC1, TCC_CC_RST, '1, "cc1 reset");
        wr(8'h18, $urandom);
        rc(8'h18, 32'h0, '1, "unmapped");
        v = $urandom;
        wr(TCC_OFS_PER, {24'h0, v[7:0]});
        wr(TCC_OFS_CC0, {16'h0, v[15:0]});
        rc(TCC_OFS_PER, {24'h0, v[7:0]}, '1, "per rw");
        rc(TCC_OFS_CC0, {16'h0, v[15:0]}, '1, "cc0 rw");
        guard <= 1'b1;
        wr(TCC_OFS_CTRL, 32'h800);
        rc(TCC_OFS_CTRL, 32'h0, '1, "guarded ctrl");
        wr(TCC_OFS_COUNT, 32'h55);
        rc(TCC_OFS_COUNT, 32'h55, '1, "count exempt");
        wr(TCC_OFS_CTRL, 32'h800, 1'b1);
        rc(TCC_OFS_CTRL, 32'h800, '1, "debugger ctrl");
        guard <= 1'b0;
        wr(TCC_OFS_CTRL, 32'h0);
        $display("test registers done");
        p = 5 + $urandom % 10;
        wr(TCC_OFS_PER, p);
        run_cnt(32'h3, 0, 40, 40, p, 2, "up8");
        run_cnt(32'h23, p, 40, 40, p, 3, "down8");
        p = 4 + $urandom % 6;
        wr(TCC_OFS_CC0, p);
        run_cnt(32'h9, 0, 30, 30, p, 2, "mfrq");
        for (int k = 0; k < 4; k++)
            run_cnt(32'h1 | (k << 8), 0, 8 * (3 + k), (8 * (3 + k)) >> k,
                    32'hffff, 32'hffff, "presc");
        run_cnt(32'h5, 32'hfffe, 4, 4, 32'hffff_ffff, 32'h1_0000,
                "cnt32");
        wr(TCC_OFS_CTRL, 32'h5);
        rc(TCC_OFS_STATUS, 32'h10, 32'h10, "pair flag");
        run_cnt(32'h81, 0, 20, 20, 32'hffff, 32'h7, "events");
        halt <= 1'b1;
        run_cnt(32'h1, 0, 10, 0, 32'hffff, 32'hffff, "halted");
        run_cnt(32'h801, 0, 10, 10, 32'hffff, 32'hffff, "dbgrun");
        halt <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            v = {16'h0, 16'($urandom)};
            wr(TCC_OFS_CC0, 32'h0);
            wr(TCC_OFS_CTRL, 32'h30c1 | (e << 16));
            wr(TCC_OFS_COUNT, v);
            p = n_m0;
            u_src.burst(1, 3, 1'b1);
            rc(TCC_OFS_CC0, v, '1, "capture value");
            rc(TCC_OFS_CC1, v, '1, "capture ch1");
            chk(n_m0 - p, 1, "capture pulse");
        end
        $display("test capture done");
        wr(TCC_OFS_CC0, 32'h5);
        wr(TCC_OFS_CC1, 32'h5);
        for (int k = 0; k < 4; k++) begin
            wr(TCC_OFS_CTRL, 32'h11 | (k[0] ? 32'hc000 : 32'h0));
            wr(TCC_OFS_COUNT, k[1] ? 32'h7 : 32'h3);
            repeat (4) @(posedge clk_sys_i);
            chk({30'h0, wo}, {30'h0, {2{~k[1] ^ k[0]}}}, "pwm");
        end
        $display("test pwm done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
